/* pic_cfg.svh */
`ifndef PIC_CFG_SVH
`define PIC_CFG_SVH
`define PIC_NSRC 24
`define PIC_NGRP 6
`define PIC_NEXT 8
`define PIC_ADDR_IE0 8'hA8
`define PIC_ADDR_IE1 8'hA9
`define PIC_ADDR_IE2 8'hAA
`define PIC_ADDR_IE3 8'hAB
`define PIC_ADDR_IPL 8'hB8
`define PIC_ADDR_IPH 8'hF8
`define PIC_ADDR_EFLG 8'hA0
`define PIC_ADDR_POL0 8'hA4
`define PIC_ADDR_POL1 8'hA5
`define PIC_ADDR_POWER_CONTROL_REG 8'h87
`define PIC_ADDR_REQ0 8'hC0
`define PIC_ADDR_REQ1 8'hC1
`define PIC_ADDR_REQ2 8'hC2
`define PIC_ADDR_STAT 8'hC3
`define PIC_GIE_BIT 7
`define PIC_NMI_SRC 0
`define PIC_EXT_BASE 1
`define PIC_VEC_STEP 8'h08
`define PIC_VEC_BASE 8'h03
`define PIC_CALL_CYC 4'h4
`define PIC_RST_8 8'h00
`endif

/* pic_pkg.sv */
package pic_pkg;
    typedef enum logic [1:0] {
        PIC_EDGE_NONE,
        PIC_EDGE_RISE,
        PIC_EDGE_FALL,
        PIC_EDGE_BOTH
    } pic_edge_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pic_bus_t;
    typedef struct packed {
        logic req;
        logic [7:0] vec_lo;
        logic [1:0] level;
    } pic_take_t;
endpackage : pic_pkg

/* pic_ctrl.sv */
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "pic_cfg.svh"
module pic_ctrl
    import pic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port
    input wire pic_bus_t bus,
    output logic [7:0] rdata,
    // request sources: bit 0 non-maskable, bits 1..8 external pins
    input wire logic [`PIC_NSRC-1:0] src_req,
    input wire logic [`PIC_NEXT-1:0] ext_pin,
    // core handshake
    input wire logic instr_last,
    input wire logic irq_ack,
    input wire logic isr_return,
    input wire logic [`PIC_NSRC-1:0] sw_clear,
    output logic irq_take,
    output logic [7:0] vector_address,
    output logic [1:0] take_level,
    output logic wake
);
    logic [7:0] irq_enable_reg0, irq_enable_reg1, irq_enable_reg2;
    logic [7:0] irq_enable_reg3, priority_low_reg, priority_high_reg;
    logic [7:0] ext_edge_select_reg0, ext_edge_select_reg1;
    logic [7:0] power_control_reg;
    logic [`PIC_NSRC-1:0] pend;
    logic [`PIC_NEXT-1:0] ext_s2, ext_s3;
    // stack of active service levels, one bit per level
    logic [3:0] active_lv;
    logic nmi_active;
    logic [3:0] call_cnt;
    pic_take_t take_q;

    wire global_irq_enable = irq_enable_reg0[`PIC_GIE_BIT];
    // bit 7 of enable register 0 is the global bit, so source 7 has no
    // individual enable of its own there; it hangs off the global bit
    wire [31:0] irq_enable_bits = {irq_enable_reg3, irq_enable_reg2,
        irq_enable_reg1, irq_enable_reg0};
    wire [`PIC_NSRC-1:0] src_en = irq_enable_bits[`PIC_NSRC-1:0];
    wire wr_hit = bus.wr;
    wire wr_ie0 = wr_hit && bus.addr == `PIC_ADDR_IE0;
    wire wr_ie1 = wr_hit && bus.addr == `PIC_ADDR_IE1;
    wire wr_ie2 = wr_hit && bus.addr == `PIC_ADDR_IE2;
    wire wr_ie3 = wr_hit && bus.addr == `PIC_ADDR_IE3;
    wire wr_ipl = wr_hit && bus.addr == `PIC_ADDR_IPL;
    wire wr_iph = wr_hit && bus.addr == `PIC_ADDR_IPH;
    wire wr_pol0 = wr_hit && bus.addr == `PIC_ADDR_POL0;
    wire wr_pol1 = wr_hit && bus.addr == `PIC_ADDR_POL1;
    wire wr_power_control_reg = wr_hit && bus.addr == `PIC_ADDR_POWER_CONTROL_REG;
    // acceptance waits a cycle so a new mask or level is never half seen
    wire wr_ctl = wr_ie0 || wr_ie1 || wr_ie2 || wr_ie3 || wr_ipl
        || wr_iph || wr_power_control_reg;

    // edge detection on synchronised pins
    wire [`PIC_NEXT-1:0] rise = ext_s2 & ~ext_s3;
    wire [`PIC_NEXT-1:0] fall = ~ext_s2 & ext_s3;
    wire [15:0] pol = {ext_edge_select_reg1, ext_edge_select_reg0};
    logic [`PIC_NEXT-1:0] ext_hit;
    always_comb begin
        for (int i = 0; i < `PIC_NEXT; i++) begin
            unique case (pic_edge_t'(pol[2*i +: 2]))
                PIC_EDGE_NONE: ext_hit[i] = 1'b0;
                PIC_EDGE_RISE: ext_hit[i] = rise[i];
                PIC_EDGE_FALL: ext_hit[i] = fall[i];
                PIC_EDGE_BOTH: ext_hit[i] = rise[i] | fall[i];
            endcase
        end
    end
    wire [`PIC_NSRC-1:0] raw_req = src_req |
        ({{(`PIC_NSRC-`PIC_NEXT-1){1'b0}}, ext_hit, 1'b0} <<
        (`PIC_EXT_BASE - 1));

    // per-source level, nmi above all maskables
    wire [`PIC_NSRC-1:0] eligible;
    wire [`PIC_NSRC-1:0][2:0] lvl;
    genvar g;
    generate
        for (g = 0; g < `PIC_NSRC; g++) begin : g_src
            if (g == `PIC_NMI_SRC) begin : g_nmi
                assign lvl[g] = 3'h4;
                assign eligible[g] = pend[g] && !nmi_active;
            end else begin : g_mask
                // two bits per group of four
                assign lvl[g] = {1'b0, priority_high_reg[g/4],
                    priority_low_reg[g/4]};
                assign eligible[g] = pend[g] && global_irq_enable
                    && src_en[g]
                    && (4'(1 << lvl[g][1:0]) > active_lv)
                    && !nmi_active;
            end
        end
    endgenerate

    // highest level wins, scanning downward so lowest number wins ties
    logic [4:0] win;
    logic [2:0] win_lv;
    logic win_ok;
    always_comb begin
        win = 5'h00;
        win_lv = 3'h0;
        win_ok = 1'b0;
        for (int i = `PIC_NSRC - 1; i >= 0; i--) begin
            if (eligible[i] && (!win_ok || lvl[i] >= win_lv)) begin
                win = 5'(i);
                win_lv = lvl[i];
                win_ok = 1'b1;
            end
        end
    end

    // accept only at instruction end, not during control writes or a call
    wire accept = win_ok && instr_last && !wr_ctl
        && call_cnt == 4'h0 && !take_q.req;
    wire [7:0] next_vec = `PIC_VEC_BASE + 8'(win) * `PIC_VEC_STEP;
    wire [`PIC_NSRC-1:0] acc_mask = accept ? (`PIC_NSRC'(1) << win) : '0;

    // enabled pending source wakes the core, whatever its level
    wire next_wake = |(pend & (src_en | `PIC_NSRC'(1)) &
        {{(`PIC_NSRC-1){global_irq_enable}}, 1'b1});

    // the running routine owns the highest active level; a return
    // retires that one and leaves the preempted levels beneath it
    logic [3:0] top_lv;
    always_comb begin
        top_lv = 4'h0;
        for (int i = 0; i < 4; i++) begin
            if (active_lv[i])
                top_lv = 4'h1 << i;
        end
    end

    // a return and a new acceptance may share one edge; keep both
    wire ret_lv = isr_return && !nmi_active;
    wire [3:0] lv_kept = ret_lv ? (active_lv & ~top_lv) : active_lv;
    wire [3:0] lv_new = (accept && win != `PIC_NMI_SRC) ?
        (4'h1 << win_lv[1:0]) : 4'h0;
    wire [3:0] next_active_lv = lv_kept | lv_new;
    wire next_nmi_active = (accept && win == `PIC_NMI_SRC)
        || (nmi_active && !isr_return);
    wire [`PIC_NEXT-1:0] eflag = pend[`PIC_EXT_BASE +: `PIC_NEXT];

    wire [7:0] next_rdata =
        bus.addr == `PIC_ADDR_IE0 ? irq_enable_reg0 :
        bus.addr == `PIC_ADDR_IE1 ? irq_enable_reg1 :
        bus.addr == `PIC_ADDR_IE2 ? irq_enable_reg2 :
        bus.addr == `PIC_ADDR_IE3 ? irq_enable_reg3 :
        bus.addr == `PIC_ADDR_IPL ? priority_low_reg :
        bus.addr == `PIC_ADDR_IPH ? priority_high_reg :
        bus.addr == `PIC_ADDR_EFLG ? eflag :
        bus.addr == `PIC_ADDR_POL0 ? ext_edge_select_reg0 :
        bus.addr == `PIC_ADDR_POL1 ? ext_edge_select_reg1 :
        bus.addr == `PIC_ADDR_POWER_CONTROL_REG ? power_control_reg :
        bus.addr == `PIC_ADDR_REQ0 ? pend[7:0] :
        bus.addr == `PIC_ADDR_REQ1 ? pend[15:8] :
        bus.addr == `PIC_ADDR_REQ2 ? pend[23:16] :
        bus.addr == `PIC_ADDR_STAT ? {3'h0, nmi_active, active_lv} :
        8'h00;

    // software write of zero clears an external flag
    wire eflg_wr = wr_hit && bus.addr == `PIC_ADDR_EFLG;
    // inverted byte kept at eight bits so the clear cannot spill
    // into the maskable sources above the pins
    wire [7:0] eflg_zero = ~bus.wdata;
    wire [`PIC_NSRC-1:0] eflg_mask = {{(`PIC_NSRC-`PIC_NEXT-1){1'b0}},
        eflg_zero, 1'b0} << (`PIC_EXT_BASE - 1);
    wire [`PIC_NSRC-1:0] sw_kill = sw_clear | (eflg_wr ? eflg_mask : '0);

    // two flops before any pin is read; a third keeps the last level
    pic_sync #(
        .WIDTH(`PIC_NEXT)
    ) pic_sync_i (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin(ext_pin),
        .level(ext_s2),
        .level_q(ext_s3)
    );

    // request latch: new requests beat clears in the same cycle
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            pend <= '0;
        else
            pend <= (pend & ~acc_mask & ~sw_kill) | raw_req;
    end

    // a software write wins outright: acceptance is held off during it
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            irq_enable_reg0 <= `PIC_RST_8;
        else if (wr_ie0)
            irq_enable_reg0 <= bus.wdata;
        else if (accept && win != `PIC_NMI_SRC)
            irq_enable_reg0[`PIC_GIE_BIT] <= 1'b0;
        else if (isr_return)
            irq_enable_reg0[`PIC_GIE_BIT] <= 1'b1;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            irq_enable_reg1 <= `PIC_RST_8;
        else if (wr_ie1)
            irq_enable_reg1 <= bus.wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            irq_enable_reg2 <= `PIC_RST_8;
        else if (wr_ie2)
            irq_enable_reg2 <= bus.wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            irq_enable_reg3 <= `PIC_RST_8;
        else if (wr_ie3)
            irq_enable_reg3 <= bus.wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            priority_low_reg <= `PIC_RST_8;
        else if (wr_ipl)
            priority_low_reg <= bus.wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            priority_high_reg <= `PIC_RST_8;
        else if (wr_iph)
            priority_high_reg <= bus.wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            ext_edge_select_reg0 <= `PIC_RST_8;
        else if (wr_pol0)
            ext_edge_select_reg0 <= bus.wdata;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            ext_edge_select_reg1 <= `PIC_RST_8;
        else if (wr_pol1)
            ext_edge_select_reg1 <= bus.wdata;
    end

    // stored for software only; its write still defers acceptance
    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            power_control_reg <= `PIC_RST_8;
        else if (wr_power_control_reg)
            power_control_reg <= bus.wdata;
    end

    // nesting record: a return from the nmi leaves the levels alone
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            active_lv <= 4'h0;
            nmi_active <= 1'b0;
        end else begin
            active_lv <= next_active_lv;
            nmi_active <= next_nmi_active;
        end
    end

    // hold the take request until the core acks, then count the
    // long call and long jump cycles before the next acceptance
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            take_q <= '0;
            call_cnt <= 4'h0;
        end else begin
            if (accept) begin
                take_q.req <= 1'b1;
                take_q.vec_lo <= next_vec;
                take_q.level <= win_lv[1:0];
            end else if (irq_ack && take_q.req) begin
                take_q.req <= 1'b0;
                call_cnt <= `PIC_CALL_CYC;
            end else if (call_cnt != 4'h0) begin
                call_cnt <= call_cnt - 4'h1;
            end
        end
    end

    // the take stands until the cycle after the core's ack
    wire next_take = accept | (take_q.req & ~irq_ack);
    wire [7:0] next_vec_out = accept ? next_vec : take_q.vec_lo;
    wire [1:0] next_level = accept ? win_lv[1:0] : take_q.level;
    wire [7:0] next_rd_out = bus.rd ? next_rdata : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            rdata <= 8'h00;
        else
            rdata <= next_rd_out;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            irq_take <= 1'b0;
        else
            irq_take <= next_take;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            vector_address <= 8'h00;
        else
            vector_address <= next_vec_out;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            take_level <= 2'h0;
        else
            take_level <= next_level;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst)
            wake <= 1'b0;
        else
            wake <= next_wake;
    end
endmodule : pic_ctrl

// pin synchroniser; level is the first value any logic may read
module pic_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // raw pins in, synchronised level and its previous value out
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] level_q
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta <= '0;
            level <= '0;
            level_q <= '0;
        end else begin
            meta <= pin;
            level <= meta;
            level_q <= level;
        end
    end
endmodule : pic_sync

/* pic_ctrl_properties.sv */
`timescale 1ns/1ps
`include "pic_cfg.svh"
module pic_chk
    import pic_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // register port and sources
    input wire pic_bus_t bus,
    input wire logic [`PIC_NSRC-1:0] src_req,
    // core handshake
    input wire logic instr_last,
    input wire logic irq_ack,
    input wire logic isr_return,
    input wire logic irq_take,
    input wire logic [7:0] vector_address,
    input wire logic [1:0] take_level,
    input wire logic wake
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    logic take_q;
    logic gie;
    wire took = irq_take && !take_q;
    wire ie0_wr = bus.wr && bus.addr == `PIC_ADDR_IE0;
    wire cfg_wr = bus.wr && ((bus.addr & 8'hFC) == `PIC_ADDR_IE0 ||
        bus.addr == `PIC_ADDR_IPL || bus.addr == `PIC_ADDR_IPH ||
        bus.addr == `PIC_ADDR_POWER_CONTROL_REG);
    // shadow of the global enable; clears one cycle late, which is safe
    // because the call blackout keeps takes far apart
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            take_q <= 1'b0;
            gie <= 1'b0;
        end else begin
            take_q <= irq_take;
            if (ie0_wr) gie <= bus.wdata[`PIC_GIE_BIT];
            else if (isr_return) gie <= 1'b1;
            else if (took && vector_address != `PIC_VEC_BASE) gie <= 1'b0;
        end
    end
    sequence s_drop;
        irq_ack ##1 !irq_take;
    endsequence
    sequence s_blackout;
        !irq_take [*4];
    endsequence
    property p_take_last;
        $rose(irq_take) |-> $past(instr_last);
    endproperty
    property p_no_cfg;
        $rose(irq_take) |-> !$past(cfg_wr);
    endproperty
    property p_vec_low;
        $rose(irq_take) |-> vector_address[2:0] == 3'h3;
    endproperty
    property p_vec_range;
        $rose(irq_take) |-> vector_address <= 8'hBB;
    endproperty
    property p_nmi_level;
        $rose(irq_take) && vector_address == `PIC_VEC_BASE |->
            take_level == 2'h0;
    endproperty
    property p_gie;
        took && vector_address != `PIC_VEC_BASE |-> $past(gie);
    endproperty
    property p_release;
        irq_take && irq_ack |-> s_drop;
    endproperty
    property p_blackout;
        $fell(irq_take) |-> s_blackout;
    endproperty
    property p_nmi_wake;
        src_req[`PIC_NMI_SRC] |-> ##[1:3] wake;
    endproperty
    property p_vec_hold;
        irq_take && $past(irq_take) |-> $stable(vector_address);
    endproperty
    a_take_last: assert property (p_take_last)
        else $error("take without last instruction cycle");
    a_no_cfg: assert property (p_no_cfg)
        else $error("take during config write");
    a_vec_low: assert property (p_vec_low)
        else $error("vector low bits wrong");
    a_vec_range: assert property (p_vec_range)
        else $error("vector beyond last source");
    a_nmi_level: assert property (p_nmi_level)
        else $error("nmi level not zero");
    a_gie: assert property (p_gie)
        else $error("maskable take with global enable clear");
    a_release: assert property (p_release)
        else $error("take not released after ack");
    a_blackout: assert property (p_blackout)
        else $error("take inside call window");
    a_nmi_wake: assert property (p_nmi_wake)
        else $error("no wake on nmi");
    a_vec_hold: assert property (p_vec_hold)
        else $error("vector moved during take");
endmodule : pic_chk
bind pic_ctrl pic_chk pic_chk_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .bus(bus), .src_req(src_req), .instr_last(instr_last),
    .irq_ack(irq_ack), .isr_return(isr_return), .irq_take(irq_take),
    .vector_address(vector_address), .take_level(take_level), .wake(wake));

/* pic_core_model.sv */
`timescale 1ns/1ps
module pic_core_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // controller side
    input wire logic irq_take,
    input wire logic ret_cmd,
    output logic instr_last,
    output logic irq_ack,
    output logic isr_return
);
    logic [2:0] step;
    logic acked;
    assign instr_last = (step == 3'h2);
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            step <= 3'h0;
            acked <= 1'b0;
            irq_ack <= 1'b0;
            isr_return <= 1'b0;
        end else begin
            // the call adds four cycles before the next instruction ends
            step <= irq_ack ? 3'h6 : (instr_last ? 3'h0 : step + 3'h1);
            irq_ack <= irq_take && !irq_ack && !acked;
            acked <= irq_take && (acked || irq_ack);
            isr_return <= ret_cmd;
        end
    end
endmodule : pic_core_model

/* tb_prioritized_irq_controller.sv */
`timescale 1ns/1ps
`include "pic_cfg.svh"
module tb_prioritized_irq_controller import pic_pkg::*;;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    pic_bus_t bus = '0;
    logic [23:0] src_req = '0;
    logic [23:0] sw_clear = '0;
    logic [7:0] ext_pin = '0;
    logic ret_cmd = 1'b0;
    logic instr_last, irq_ack, isr_return, irq_take, wake;
    logic [7:0] rdata, vector_address;
    logic [1:0] take_level;
    int failures = 0;
    int checks = 0;
    always #2 sys_clk = ~sys_clk;
    pic_ctrl pic_ctrl_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .src_req(src_req), .ext_pin(ext_pin),
        .instr_last(instr_last), .irq_ack(irq_ack), .isr_return(isr_return),
        .sw_clear(sw_clear), .irq_take(irq_take), .wake(wake),
        .vector_address(vector_address), .take_level(take_level));
    pic_core_model pic_core_model_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .irq_take(irq_take), .ret_cmd(ret_cmd), .instr_last(instr_last),
        .irq_ack(irq_ack), .isr_return(isr_return));
    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        bus.rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, rdata);
    endtask : rd
    task automatic pulse(input logic [23:0] m);
        @(posedge sys_clk);
        src_req <= m;
        @(posedge sys_clk);
        src_req <= '0;
    endtask : pulse
    task automatic ret;
        @(posedge sys_clk);
        ret_cmd <= 1'b1;
        @(posedge sys_clk);
        ret_cmd <= 1'b0;
    endtask : ret
    task automatic quiet(input int n);
        logic seen;
        seen = 1'b0;
        repeat (n) begin
            @(posedge sys_clk);
            #1 seen = seen | irq_take;
        end
        chk("no take", 8'h00, {7'h00, seen});
    endtask : quiet
    task automatic take(input logic [7:0] vec, input logic [1:0] lvl);
        int n;
        n = 0;
        while (irq_take !== 1'b1 && n < 60) begin
            @(posedge sys_clk);
            #1 n++;
        end
        if (irq_take !== 1'b1) begin
            failures++;
            $display("ERROR irq_take expected 1 seen 0");
            summarize();
        end else begin
            chk("vector", vec, vector_address);
            chk("level", {6'h00, lvl}, {6'h00, take_level});
            repeat (3) @(posedge sys_clk);
        end
    endtask : take
    task automatic t_reset;
        rd(`PIC_ADDR_IE0, 8'h00);
        rd(`PIC_ADDR_IPL, 8'h00);
        rd(`PIC_ADDR_IPH, 8'h00);
        rd(`PIC_ADDR_POL0, 8'h00);
        rd(8'h00, 8'h00);
    endtask : t_reset
    task automatic t_gie;
        wr(`PIC_ADDR_IE0, 8'h20);
        pulse(24'h000020);
        quiet(20);
        rd(`PIC_ADDR_REQ0, 8'h20);
        @(posedge sys_clk);
        sw_clear <= 24'h000020;
        @(posedge sys_clk);
        sw_clear <= '0;
        rd(`PIC_ADDR_REQ0, 8'h00);
        pulse(24'h000020);
        wr(`PIC_ADDR_IE0, 8'hA0);
        take(8'h2B, 2'h0);
        rd(`PIC_ADDR_IE0, 8'h20);
        rd(`PIC_ADDR_REQ0, 8'h00);
        ret();
        rd(`PIC_ADDR_IE0, 8'hA0);
    endtask : t_gie
    task automatic t_prio;
        wr(`PIC_ADDR_IE1, 8'h06);
        wr(`PIC_ADDR_IPL, 8'h04);
        pulse(24'h000620);
        take(8'h4B, 2'h1);
        wr(`PIC_ADDR_IE0, 8'hA0);
        quiet(20);
        chk("wake", 8'h01, {7'h00, wake});
        wr(`PIC_ADDR_IPH, 8'h08);
        wr(`PIC_ADDR_IE1, 8'h16);
        pulse(24'h001000);
        take(8'h63, 2'h2);
        ret();
        rd(`PIC_ADDR_STAT, 8'h02);
        ret();
        take(8'h53, 2'h1);
        ret();
        take(8'h2B, 2'h0);
        ret();
    endtask : t_prio
    task automatic t_nmi;
        wr(`PIC_ADDR_IE0, 8'h00);
        pulse(24'h000001);
        take(8'h03, 2'h0);
        ret();
    endtask : t_nmi
    task automatic t_ext;
        wr(`PIC_ADDR_POL0, 8'h01);
        wr(`PIC_ADDR_IE0, 8'h02);
        @(posedge sys_clk);
        ext_pin[0] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(`PIC_ADDR_EFLG, 8'h01);
        wr(`PIC_ADDR_EFLG, 8'h00);
        rd(`PIC_ADDR_EFLG, 8'h00);
        @(posedge sys_clk);
        ext_pin[0] <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(`PIC_ADDR_EFLG, 8'h00);
        wr(`PIC_ADDR_POL0, 8'h03);
        wr(`PIC_ADDR_IE0, 8'h82);
        ext_pin[0] <= 1'b1;
        take(8'h0B, 2'h0);
        ret();
        rd(`PIC_ADDR_EFLG, 8'h00);
    endtask : t_ext
    task automatic summarize;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset();
        t_gie();
        t_prio();
        t_nmi();
        t_ext();
        summarize();
    end
endmodule : tb_prioritized_irq_controller
